// ### logic/hbt_host_bus_target.sv
/*
 Host bus target: ISA and local bus decode, claim, sizing, wait states,
 cycle termination, retrace interrupt and strap capture.
 Assumes every bus pin is asynchronous to CLK_SYS_I and that open-drain
 and tristate pins are resolved outside from the _OEN_O enables.
*/
// Notes on behaviour
// - Master cycle in add-on configuration passes unlatched upper address through.
// - Retrace interrupt only when its enable bit set.
// - System reset resets core, loads straps.
// - Memory window hit drives wide-memory low.
// - Address latch enable captures upper address bits.
// - No-wait output low for zero-wait cycles.
// - Own I/O decode drives wide-I/O low.
// - High byte enable with bit 0 sizes cycle.
// - Refresh cycles are never own accesses.
// - Channel ready low while memory is busy.
// - Address enable high blocks I/O decode.
// - Bus reset clears state, floats buses, straps.
// - Sample status on processor clock, 1X/2X.
// - Byte enables select active data lanes.
// - Claimed cycles drive local bus claim low.
// - Cycle ends on returned ready input.
// - Ready driven high one tick before release.
// - Fast write readies first T2, else third.
// - Combined command yields palette and enable strobes.
// - Write/read and memory/IO status are decoded.
`default_nettype none
`include "hbt_regs.svh"
module hbt_host_bus_target (
   // Clock and reset.
   input wire logic CLK_SYS_I,
   input wire logic RSTN_I,
   // Configuration and core status.
   input wire logic BUS_IS_VL_I,
   input wire logic ADD_ON_CFG_I,
   input wire logic FAST_WRITE_I,
   input wire logic CLK_2X_I,
   input wire logic RETRACE_IRQ_EN_I,
   input wire logic VRETRACE_I,
   input wire logic MEM_BUSY_I,
   // ISA pins.
   input wire logic MASTER_N_I,
   input wire logic MWR_N_I,
   input wire logic MRD_N_I,
   input wire logic IOR_N_I,
   input wire logic IOW_N_I,
   input wire logic [6:0] LA_I,
   input wire logic [16:0] SA_I,
   input wire logic BHE_N_I,
   input wire logic ALE_I,
   input wire logic RFSH_N_I,
   input wire logic AEN_I,
   input wire logic [15:0] MD_I,
   // Local bus pins.
   input wire logic PROCLK_I,
   input wire logic ADS_N_I,
   input wire logic [29:0] VL_ADDR_I,
   input wire logic [3:0] BE_N_I,
   input wire logic READY_RETURN_IN_N_I,
   input wire logic COMBINED_COMMAND_IN_I,
   input wire logic WRITE_NOT_READ_IN_I,
   input wire logic MEMORY_NOT_IO_IN_I,
   // Open-drain and tristate pins; enable low drives the pin.
   output logic RETRACE_IRQ_OUT_O,
   output logic RETRACE_IRQ_OUT_OEN_O,
   output logic WIDE_MEMORY_CYCLE_OUT_O,
   output logic WIDE_MEMORY_CYCLE_OUT_OEN_O,
   output logic NO_WAIT_CYCLE_OUT_O,
   output logic NO_WAIT_CYCLE_OUT_OEN_O,
   output logic WIDE_IO_CYCLE_OUT_O,
   output logic WIDE_IO_CYCLE_OUT_OEN_O,
   output logic IOCHRDY_O,
   output logic IOCHRDY_OEN_O,
   output logic LOCAL_BUS_CLAIM_OUT_O,
   output logic LOCAL_BUS_CLAIM_OUT_OEN_O,
   output logic CYCLE_READY_OUT_O,
   output logic CYCLE_READY_OUT_OEN_O,
   output logic DATA_BUS_OEN_O,
   // Core side.
   output logic CORE_RESET_N_O,
   output logic [15:0] CFG_STRAP_O,
   output logic [6:0] PASS_ADDR_O,
   output logic [2:0] LATCHED_SA_O,
   output logic WIDE_XFER_O,
   output logic [3:0] LANE_SEL_O,
   output logic VL_WRITE_O,
   output logic VL_MEM_O,
   output logic ACCESS_START_O,
   output logic DAC_RD_N_O,
   output logic DAC_WR_N_O,
   output logic DATA_OE_N_O
);
   // Width of the bundle of asynchronous pins.
   localparam int AW = 89;
   // Open-drain pins only ever pull low; the tristate ready carries a value.
   assign RETRACE_IRQ_OUT_O = 1'b0;
   assign WIDE_MEMORY_CYCLE_OUT_O = 1'b0;
   assign NO_WAIT_CYCLE_OUT_O = 1'b0;
   assign WIDE_IO_CYCLE_OUT_O = 1'b0;
   assign IOCHRDY_O = 1'b0;
   assign LOCAL_BUS_CLAIM_OUT_O = 1'b0;

   // True when a latched address falls in a range.
   function automatic logic in_rng(input logic [19:0] a, input logic [19:0] lo,
                                   input logic [19:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction : in_rng

   // Two-stage synchroniser for all pins; only s2_q is read.
   logic [AW-1:0] s1_q;
   logic [AW-1:0] s2_q;
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= {MASTER_N_I, MWR_N_I, MRD_N_I, IOR_N_I, IOW_N_I, LA_I, SA_I,
                  BHE_N_I, ALE_I, RFSH_N_I, AEN_I, MD_I, PROCLK_I, ADS_N_I,
                  VL_ADDR_I, BE_N_I, READY_RETURN_IN_N_I,
                  COMBINED_COMMAND_IN_I, WRITE_NOT_READ_IN_I,
                  MEMORY_NOT_IO_IN_I};
         s2_q <= s1_q;
      end
   end
   // Synchronised pin copies.
   logic master_n_s, mwr_n_s, mrd_n_s, ior_n_s, iow_n_s;
   logic [6:0] la_s;
   logic [16:0] sa_s;
   logic bhe_n_s, ale_s, rfsh_n_s, aen_s;
   logic [15:0] md_s;
   logic pk_s, ads_n_s;
   logic [29:0] vla_s;
   logic [3:0] be_n_s;
   logic ret_n_s, cmd_s, wr_s, mio_s;
   assign {master_n_s, mwr_n_s, mrd_n_s, ior_n_s, iow_n_s, la_s, sa_s,
           bhe_n_s, ale_s, rfsh_n_s, aen_s, md_s, pk_s, ads_n_s, vla_s,
           be_n_s, ret_n_s, cmd_s, wr_s, mio_s} = s2_q;

   // Strap capture after the pins have settled past reset release.
   logic [1:0] dly_q;
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         dly_q <= 2'h0;
         CORE_RESET_N_O <= 1'b0;
         CFG_STRAP_O <= `HBT_STRAP_RST;
      end else if (dly_q != `HBT_STRAP_DLY) begin
         dly_q <= dly_q + 2'h1;
      end else if (!CORE_RESET_N_O) begin
         CORE_RESET_N_O <= 1'b1;
         CFG_STRAP_O <= md_s;
      end
   end
   // Data buses stay floated until the core leaves reset.
   assign DATA_BUS_OEN_O = !CORE_RESET_N_O;

   // Retrace interrupt, gated by its enable bit.
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) RETRACE_IRQ_OUT_OEN_O <= 1'b1;
      else RETRACE_IRQ_OUT_OEN_O <= !(RETRACE_IRQ_EN_I && VRETRACE_I);
   end

   // ISA decode on synchronised pins.
   logic [19:0] sa_full;
   logic mem_hit, io_hit, dac_hit, mem_cmd, io_cmd;
   assign sa_full = {LATCHED_SA_O, sa_s[16:0]};
   assign mem_hit = !BUS_IS_VL_I && rfsh_n_s && (la_s == `HBT_MEM_WIN);
   assign io_hit = !BUS_IS_VL_I && rfsh_n_s && !aen_s &&
                   in_rng(sa_full, `HBT_IO_LO, `HBT_IO_HI);
   // Palette decode is an I/O decode: refresh and DMA cycles never reach it.
   assign dac_hit = rfsh_n_s && !aen_s &&
                    in_rng(sa_full, `HBT_DAC_LO, `HBT_DAC_HI);
   assign mem_cmd = mem_hit && !(mrd_n_s && mwr_n_s);
   assign io_cmd = io_hit && !(ior_n_s && iow_n_s);

   // Upper address: transparent in master cycles in add-on configuration, else held by ALE.
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         PASS_ADDR_O <= 7'h00;
         LATCHED_SA_O <= 3'h0;
      end else begin
         if ((ADD_ON_CFG_I && !master_n_s) || ale_s) PASS_ADDR_O <= la_s;
         if (ale_s) LATCHED_SA_O <= la_s[2:0];
      end
   end

   // ISA size and wait-state indications.
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         WIDE_MEMORY_CYCLE_OUT_OEN_O <= 1'b1;
         WIDE_IO_CYCLE_OUT_OEN_O <= 1'b1;
         NO_WAIT_CYCLE_OUT_OEN_O <= 1'b1;
         IOCHRDY_OEN_O <= 1'b1;
         WIDE_XFER_O <= 1'b0;
      end else begin
         WIDE_MEMORY_CYCLE_OUT_OEN_O <= !mem_hit;
         WIDE_IO_CYCLE_OUT_OEN_O <= !io_hit;
         // Busy memory stretches the cycle; idle memory ends it at once.
         NO_WAIT_CYCLE_OUT_OEN_O <= !(mem_cmd && !MEM_BUSY_I);
         IOCHRDY_OEN_O <= !(mem_cmd && MEM_BUSY_I);
         WIDE_XFER_O <= !bhe_n_s && !sa_s[0];
      end
   end

   // Access start on the first sample of a decoded command.
   logic cmd_d_q;
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         cmd_d_q <= 1'b0;
         ACCESS_START_O <= 1'b0;
      end else begin
         cmd_d_q <= mem_cmd || io_cmd;
         ACCESS_START_O <= (mem_cmd || io_cmd) && !cmd_d_q;
      end
   end

   // Palette strobes and data enable from the combined command.
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         DAC_RD_N_O <= 1'b1;
         DAC_WR_N_O <= 1'b1;
         DATA_OE_N_O <= 1'b1;
      end else begin
         DAC_RD_N_O <= !(cmd_s && dac_hit && iow_n_s);
         DAC_WR_N_O <= !(cmd_s && dac_hit && !iow_n_s);
         DATA_OE_N_O <= !cmd_s;
      end
   end

   // Processor clock tick: rising edge, every other one in 2X mode.
   logic pk_d_q, ph_q, pk_tick;
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         pk_d_q <= 1'b0;
         ph_q <= 1'b0;
      end else begin
         pk_d_q <= pk_s;
         if (pk_s && !pk_d_q) ph_q <= !ph_q;
      end
   end
   assign pk_tick = pk_s && !pk_d_q && (!CLK_2X_I || ph_q);

   // Local bus decode of the presented address and status.
   logic vl_hit;
   assign vl_hit = BUS_IS_VL_I && (mio_s ? (vla_s[29:15] == `HBT_VL_MEM_WIN) :
                   in_rng({vla_s[17:0], 2'b00}, `HBT_IO_LO, `HBT_IO_HI));

   // Local bus cycle sequencer.
   hbt_pkg::hbt_vl_state_t vst_q;
   logic ret_seen_q;
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         vst_q <= hbt_pkg::VL_IDLE;
         ret_seen_q <= 1'b0;
         VL_WRITE_O <= 1'b0;
         VL_MEM_O <= 1'b0;
         LANE_SEL_O <= 4'h0;
         LOCAL_BUS_CLAIM_OUT_OEN_O <= 1'b1;
         CYCLE_READY_OUT_O <= 1'b1;
         CYCLE_READY_OUT_OEN_O <= 1'b1;
      end else if (pk_tick) begin
         if (vst_q != hbt_pkg::VL_IDLE && !ret_n_s) ret_seen_q <= 1'b1;
         unique case (vst_q)
            hbt_pkg::VL_IDLE: begin
               ret_seen_q <= 1'b0;
               // Host marks a valid address with address status low.
               if (!ads_n_s && vl_hit) begin
                  VL_WRITE_O <= wr_s;
                  VL_MEM_O <= mio_s;
                  LANE_SEL_O <= ~be_n_s;
                  LOCAL_BUS_CLAIM_OUT_OEN_O <= 1'b0;
                  vst_q <= hbt_pkg::VL_FIRST;
                  if (FAST_WRITE_I && wr_s) begin
                     CYCLE_READY_OUT_O <= 1'b0;
                     CYCLE_READY_OUT_OEN_O <= 1'b0;
                  end
               end
            end
            hbt_pkg::VL_FIRST: begin
               // A fast write already readied; others wait a T2.
               vst_q <= CYCLE_READY_OUT_OEN_O ? hbt_pkg::VL_SECOND :
                        hbt_pkg::VL_HIGH;
               if (!CYCLE_READY_OUT_OEN_O) CYCLE_READY_OUT_O <= 1'b1;
            end
            hbt_pkg::VL_SECOND: begin
               if (!VL_MEM_O || !MEM_BUSY_I) begin
                  CYCLE_READY_OUT_O <= 1'b0;
                  CYCLE_READY_OUT_OEN_O <= 1'b0;
                  vst_q <= hbt_pkg::VL_RDY;
               end
            end
            hbt_pkg::VL_RDY: begin
               CYCLE_READY_OUT_O <= 1'b1;
               vst_q <= hbt_pkg::VL_HIGH;
            end
            hbt_pkg::VL_HIGH: begin
               CYCLE_READY_OUT_OEN_O <= 1'b1;
               vst_q <= hbt_pkg::VL_WAIT;
            end
            hbt_pkg::VL_WAIT: begin
               // Claim holds until the returned ready closes the cycle.
               if (ret_seen_q || !ret_n_s) begin
                  LOCAL_BUS_CLAIM_OUT_OEN_O <= 1'b1;
                  vst_q <= hbt_pkg::VL_IDLE;
               end
            end
         endcase
      end
   end

   // Checks of the design's own outputs.
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RSTN_I);
   a_irq_gate: assert property (!RETRACE_IRQ_OUT_OEN_O |->
      $past(RETRACE_IRQ_EN_I && VRETRACE_I)) else $error("irq without enable");
   a_m16_decode: assert property (!WIDE_MEMORY_CYCLE_OUT_OEN_O |->
      $past(rfsh_n_s && la_s == `HBT_MEM_WIN)) else $error("bad m16");
   a_io_aen_block: assert property ($past(aen_s) |-> WIDE_IO_CYCLE_OUT_OEN_O)
      else $error("io decoded under aen");
   a_wait_excl: assert property (NO_WAIT_CYCLE_OUT_OEN_O || IOCHRDY_OEN_O)
      else $error("zero wait and wait together");
   a_claim_rdy: assert property (!CYCLE_READY_OUT_OEN_O |-> !LOCAL_BUS_CLAIM_OUT_OEN_O)
      else $error("ready without claim");
   a_rdy_release: assert property (vst_q == hbt_pkg::VL_HIGH && pk_tick |=>
      CYCLE_READY_OUT_OEN_O) else $error("ready not released");
   a_rdy_high_tick: assert property (vst_q == hbt_pkg::VL_HIGH |->
      !CYCLE_READY_OUT_OEN_O && CYCLE_READY_OUT_O) else $error("no high tick");
   a_fast_first: assert property (vst_q == hbt_pkg::VL_IDLE && pk_tick && !ads_n_s &&
      vl_hit && FAST_WRITE_I && wr_s |=> !CYCLE_READY_OUT_OEN_O && !CYCLE_READY_OUT_O)
      else $error("fast write not readied in first T2");
   a_start_once: assert property (ACCESS_START_O |=> !ACCESS_START_O)
      else $error("start longer than one cycle");
   a_strap_load: assert property ($rose(CORE_RESET_N_O) |-> CFG_STRAP_O == $past(md_s))
      else $error("strap not loaded");
   c_fast_write: cover property (vst_q == hbt_pkg::VL_FIRST && !CYCLE_READY_OUT_OEN_O);
   c_slow_cycle: cover property (vst_q == hbt_pkg::VL_RDY);
   c_isa_wait: cover property (!IOCHRDY_OEN_O);
   c_irq: cover property (!RETRACE_IRQ_OUT_OEN_O);
endmodule : hbt_host_bus_target
`default_nettype wire

// ### logic/hbt_pkg.sv
/*
 Types of the host bus target.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package hbt_pkg;
   // Phases of one local bus cycle, counted on processor clock ticks.
   typedef enum logic [2:0] {
      VL_IDLE, VL_FIRST, VL_SECOND, VL_RDY, VL_HIGH, VL_WAIT
   } hbt_vl_state_t;
endpackage : hbt_pkg
`default_nettype wire

// ### logic/hbt_regs.svh
/*
 Constants of the host bus target: decode windows, strap reset value
 and the settle count for the strap capture.
 Assumes inclusion by bare name from the design file and the test bench.
*/
`ifndef HBT_REGS_SVH
`define HBT_REGS_SVH
// Video memory window on unlatched address bits 23 to 17.
`define HBT_MEM_WIN 7'h05
// Video memory window on local bus address bits 31 to 17.
`define HBT_VL_MEM_WIN 15'h0005
// Claimed I/O range on the latched address.
`define HBT_IO_LO 20'h003B0
`define HBT_IO_HI 20'h003DF
// Palette converter register range inside the I/O range.
`define HBT_DAC_LO 20'h003C6
`define HBT_DAC_HI 20'h003C9
// Configuration value held until the strap capture.
`define HBT_STRAP_RST 16'h0000
// Clock edges after reset release before the straps are taken.
`define HBT_STRAP_DLY 2'h3
`endif

// ### tb/hbt_host_bus_target_test.sv
/*
 Self-checking bench of the host bus target: ISA decode at random, local bus cycles, resets.
 Assumes the design's constants header and the local bus host model.
*/
`default_nettype none
`include "hbt_regs.svh"
module hbt_host_bus_target_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rstn, bus_vl, fast_wr, clk2x, irq_en, vretr, mem_busy, master_n, iow_n;
   logic add_on, mrd_n, mwr_n, ior_n, acc_st, pre, mc;
   logic [6:0] la1;
   int n_start = 0;
   int n0;
   logic bhe_n, ale, rfsh_n, aen, cmd, proclk, ads_n, rtn_n, wr, mio, rdy, rdy_oen;
   logic irq_oen, wm_oen, nw_oen, wio_oen, chrdy_oen, claim_oen, dbus_oen, core_rst_n;
   logic wide, vl_wr, vl_mem, dac_rd_n, dac_wr_n, doe_n, ok, seen, mh, ih, dh;
   logic [6:0] la, pass_addr;
   logic [16:0] sa;
   logic [15:0] md, strap;
   logic [29:0] vaddr, a;
   logic [3:0] be_n, lanes, be;
   logic [2:0] lat, lat_sa;
   logic [31:0] r;
   int seed = 32'h9558;
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   int low_at;
   hbt_host_bus_target dut (
      .CLK_SYS_I(clk), .RSTN_I(rstn), .BUS_IS_VL_I(bus_vl), .ADD_ON_CFG_I(add_on),
      .FAST_WRITE_I(fast_wr), .CLK_2X_I(clk2x), .RETRACE_IRQ_EN_I(irq_en),
      .VRETRACE_I(vretr), .MEM_BUSY_I(mem_busy), .MASTER_N_I(master_n), .MWR_N_I(mwr_n),
      .MRD_N_I(mrd_n), .IOR_N_I(ior_n), .IOW_N_I(iow_n), .LA_I(la), .SA_I(sa),
      .BHE_N_I(bhe_n), .ALE_I(ale), .RFSH_N_I(rfsh_n), .AEN_I(aen), .MD_I(md),
      .PROCLK_I(proclk), .ADS_N_I(ads_n), .VL_ADDR_I(vaddr), .BE_N_I(be_n),
      .READY_RETURN_IN_N_I(rtn_n), .COMBINED_COMMAND_IN_I(cmd), .WRITE_NOT_READ_IN_I(wr),
      .MEMORY_NOT_IO_IN_I(mio), .RETRACE_IRQ_OUT_O(), .RETRACE_IRQ_OUT_OEN_O(irq_oen),
      .WIDE_MEMORY_CYCLE_OUT_O(), .WIDE_MEMORY_CYCLE_OUT_OEN_O(wm_oen),
      .NO_WAIT_CYCLE_OUT_O(), .NO_WAIT_CYCLE_OUT_OEN_O(nw_oen), .WIDE_IO_CYCLE_OUT_O(),
      .WIDE_IO_CYCLE_OUT_OEN_O(wio_oen), .IOCHRDY_O(), .IOCHRDY_OEN_O(chrdy_oen),
      .LOCAL_BUS_CLAIM_OUT_O(), .LOCAL_BUS_CLAIM_OUT_OEN_O(claim_oen),
      .CYCLE_READY_OUT_O(rdy), .CYCLE_READY_OUT_OEN_O(rdy_oen), .DATA_BUS_OEN_O(dbus_oen),
      .CORE_RESET_N_O(core_rst_n), .CFG_STRAP_O(strap), .PASS_ADDR_O(pass_addr),
      .LATCHED_SA_O(lat_sa), .WIDE_XFER_O(wide), .LANE_SEL_O(lanes), .VL_WRITE_O(vl_wr),
      .VL_MEM_O(vl_mem), .ACCESS_START_O(acc_st), .DAC_RD_N_O(dac_rd_n), .DAC_WR_N_O(dac_wr_n),
      .DATA_OE_N_O(doe_n));
   hbt_vl_host host (
      .proclk_o(proclk), .ads_n_o(ads_n), .addr_o(vaddr), .be_n_o(be_n), .wr_o(wr),
      .mio_o(mio), .rtn_n_o(rtn_n), .rdy_i(rdy), .rdy_oen_i(rdy_oen),
      .claim_oen_i(claim_oen));
   // System clock of 8 ns.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Cuts a hung run short well after the expected length.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   // Counts access start pulses; each stands one cycle, so one falling edge sees it.
   always @(negedge clk) begin
      if (acc_st === 1'b1) n_start++;
   end
   // Waits whole cycles, then a small offset so driving and sampling stay off the edge.
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // Compares one observed value with its expectation.
   task automatic check(input string what, input logic [31:0] seen_v, exp_v);
      n_checks++;
      if (seen_v !== exp_v) begin
         n_fail++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp_v, seen_v);
      end
   endtask : check
   // True when an address lies inside a window.
   function automatic logic in_win(input logic [19:0] x, lo, hi);
      return x >= lo && x <= hi;
   endfunction : in_win
   // Whether the ISA pins of the moment make a command that the target owns.
   function automatic logic own_cmd();
      return rfsh_n && ((la == `HBT_MEM_WIN && !(mrd_n && mwr_n)) ||
             (!aen && in_win({lat, sa}, `HBT_IO_LO, `HBT_IO_HI) && !(ior_n && iow_n)));
   endfunction : own_cmd
   // Holds reset with given strap levels, then checks the idle and released states.
   task automatic do_reset(input logic [15:0] v);
      rstn = 1'b0;
      md = v;
      step(10);
      check("idle", {irq_oen, wm_oen, nw_oen, wio_oen, chrdy_oen}, 5'h1F);
      check("idle claim", {claim_oen, dbus_oen}, 2'h3);
      check("core reset", core_rst_n, 1'b0);
      rstn = 1'b1;
      step(8);
      check("strap", strap, v);
      check("running", {core_rst_n, dbus_oen}, 2'b10);
   endtask : do_reset
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop
   // Main sequence: reset, random ISA decode, local bus cycles, reset again in mid-run.
   initial begin
      {bus_vl, fast_wr, clk2x, irq_en, vretr, mem_busy, master_n, bhe_n, ale, aen, cmd} = '0;
      {iow_n, rfsh_n, add_on, mrd_n, mwr_n, ior_n} = 6'h3F;
      la = 7'h0;
      sa = 17'h0;
      do_reset(16'hA55A);
      for (int i = 0; i < 200; i++) begin
         r = $random(seed);
         lat = r[31] ? 3'h0 : r[30:28];
         la = {r[27:24], lat};
         la1 = la;
         ale = 1'b1;
         step(5);
         check("latched", lat_sa, lat);
         // Decode before the new command; starts are counted from here on.
         pre = own_cmd();
         n0 = n_start;
         r = $random(seed);
         la = (r[1:0] == 2'b00) ? `HBT_MEM_WIN : r[8:2];
         sa = r[9] ? 17'h003B0 + r[15:10] : r[26:10];
         ale = 1'b0;
         aen = r[27] & r[28];
         rfsh_n = ~(r[29] & r[30]);
         bhe_n = r[31];
         r = $random(seed);
         {master_n, mem_busy, vretr, irq_en, ior_n, iow_n, mrd_n, mwr_n, add_on} = r[8:0];
         // The board forms the combined command from the three strobes.
         cmd = !(ior_n && iow_n && mrd_n);
         step(5);
         mh = rfsh_n && la == `HBT_MEM_WIN;
         mc = mh && !(mrd_n && mwr_n);
         ih = rfsh_n && !aen && in_win({lat, sa}, `HBT_IO_LO, `HBT_IO_HI);
         dh = rfsh_n && !aen && in_win({lat, sa}, `HBT_DAC_LO, `HBT_DAC_HI);
         check("wide mem", wm_oen, !mh);
         check("wide io", wio_oen, !ih);
         check("no wait", nw_oen, !(mc && !mem_busy));
         check("chan ready", chrdy_oen, !(mc && mem_busy));
         check("wide xfer", wide, !bhe_n && !sa[0]);
         check("retrace", irq_oen, !(vretr && irq_en));
         check("pass addr", pass_addr, (add_on && !master_n) ? la : la1);
         check("data oe", doe_n, !cmd);
         check("dac rd", dac_rd_n, !(cmd && dh && iow_n));
         check("dac wr", dac_wr_n, !(cmd && dh && !iow_n));
         check("start", n_start - n0, !pre && own_cmd());
         if (i == 100) do_reset(r[31:16]);
      end
      bus_vl = 1'b1;
      mem_busy = 1'b0;
      for (int j = 0; j < 17; j++) begin
         r = $random(seed);
         fast_wr = j[0];
         clk2x = j[4];
         be = r[19:16];
         a = j[2] ? {`HBT_VL_MEM_WIN, r[14:0]} : 30'h000000F1;
         if (j[3]) a = j[2] ? {15'h0006, r[14:0]} : 30'h00000100;
         host.run(a, be, j[1], j[2], j[4] ? 2 : 1, low_at, ok, seen);
         check("claim", seen, !j[3]);
         if (!j[3]) check("lanes", lanes, 4'(~be));
         if (!j[3]) check("status", {vl_wr, vl_mem}, {j[1], j[2]});
         if (!j[3] && !j[4]) check("ready tick", low_at, (j[0] && j[1]) ? 1 : 3);
         if (!j[3] && !j[4]) check("ready tail", ok, 1'b1);
         if (!j[4]) check("claim end", claim_oen, 1'b1);
         step(3);
      end
      report_and_stop();
   end
endmodule : hbt_host_bus_target_test
`default_nettype wire

// ### tb/hbt_vl_host.sv
/*
 Host side of the local bus: runs one cycle at a time and records the ready line per tick.
 Assumes the ready pin is pulled up while released and that the board loops it back.
*/
`default_nettype none
module hbt_vl_host (
   // Pins driven toward the target.
   output logic proclk_o,
   output logic ads_n_o,
   output logic [29:0] addr_o,
   output logic [3:0] be_n_o,
   output logic wr_o,
   output logic mio_o,
   output logic rtn_n_o,
   // Pins seen from the target.
   input wire logic rdy_i,
   input wire logic rdy_oen_i,
   input wire logic claim_oen_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic rdy_w; // Resolved ready line; the pull-up wins once released.
   assign rdy_w = rdy_oen_i ? 1'b1 : rdy_i;
   // No chipset return signal here, so the board loops ready back.
   assign rtn_n_o = rdy_w;
   // The processor clock stands still between cycles.
   initial begin
      proclk_o = 1'b0;
      ads_n_o = 1'b1;
      addr_o = 30'h0;
      be_n_o = 4'hF;
      wr_o = 1'b0;
      mio_o = 1'b0;
   end
   // One cycle of ten processor clock periods; the ready history gives when and how it ended.
   task automatic run(input logic [29:0] a, input logic [3:0] be, input logic w, m,
                      input int ads_len, output int low_at, output logic ok, seen);
      logic [1:0] hist [10];
      low_at = -1;
      seen = 1'b0;
      addr_o = a;
      be_n_o = be;
      wr_o = w;
      mio_o = m;
      ads_n_o = 1'b0;
      for (int k = 0; k < 10; k++) begin
         #62.5 proclk_o = 1'b1;
         hist[k] = {rdy_oen_i, rdy_w};
         if (!claim_oen_i) seen = 1'b1;
         if (low_at < 0 && hist[k] == 2'b00) low_at = k;
         // Status is held well past the edge, so the target's synchroniser
         // captures it together with that edge.
         #20 if (k + 1 >= ads_len) ads_n_o = 1'b1;
         #42.5 proclk_o = 1'b0;
      end
      ok = low_at >= 0 && low_at < 8 && hist[low_at + 1] == 2'b01 && hist[low_at + 2][1];
      // Released address and byte enable lines do not keep their last value.
      addr_o = ~a;
      be_n_o = ~be;
   endtask : run
endmodule : hbt_vl_host
`default_nettype wire
